//--- clk_synth_pkg.sv
// Shared constants, types and configuration layout for the clock synthesis
// control block. Assumes a single 25 MHz core clock that stands for half a
// VCO period per cycle.
package clk_synth_pkg;

    localparam int REF_W = 12;
    localparam int FB_W = 14;
    localparam int POST_W = 8;
    localparam int POST_STAGES = 3;
    localparam int DIV_W = 14;
    localparam int TOTAL_W = 24;
    localparam int PIN_COUNT = 3;
    localparam int PIN_XTAL = 0;
    localparam int PIN_REF = 1;
    localparam int PIN_SYNC = 2;

    localparam logic [REF_W-1:0] REF_MOD_RESET = 12'h001;
    localparam logic [FB_W-1:0] FB_MOD_RESET = 14'h000C;
    localparam logic [FB_W-1:0] FB_MOD_FULL_MIN = 14'h000C;
    localparam logic [FB_W-1:0] FB_MOD_4 = 14'h0004;
    localparam logic [FB_W-1:0] FB_MOD_5 = 14'h0005;
    localparam logic [FB_W-1:0] FB_MOD_8 = 14'h0008;
    localparam logic [FB_W-1:0] FB_MOD_9 = 14'h0009;
    localparam logic [FB_W-1:0] FB_MOD_10 = 14'h000A;
    localparam logic [POST_W-1:0] POST_MOD_RESET = 8'h01;

    localparam int CLK_PERIOD_NS = 40;
    localparam int SYNC_DELAY_NS = 200;
    localparam int SYNC_DELAY_CYCLES_RAW =
        (SYNC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_DELAY_CYCLES =
        (SYNC_DELAY_CYCLES_RAW < 1) ? 1 : SYNC_DELAY_CYCLES_RAW;
    localparam int DLY_W = 4;
    localparam logic [DLY_W-1:0] SYNC_DELAY_LOAD =
        DLY_W'(SYNC_DELAY_CYCLES - 1);

    typedef enum logic [1:0] {
        SYNC_RUN,
        SYNC_HALT,
        SYNC_STOP,
        SYNC_ALIGN
    } sync_state_e;

    typedef struct packed {
        logic [REF_W-1:0] ref_div_modulus;
        logic [FB_W-1:0] feedback_divider_field;
        logic [POST_STAGES-1:0][POST_W-1:0] post_mod;
        logic ref_source_select;
        logic feedback_source_select;
        logic function_shutdown;
        logic power_shutdown;
        logic pecl_mode;
        logic sync_rising_active;
    } cfg_s;

    localparam cfg_s CFG_RESET = '{
        ref_div_modulus: REF_MOD_RESET,
        feedback_divider_field: FB_MOD_RESET,
        post_mod: {POST_STAGES{POST_MOD_RESET}},
        ref_source_select: 1'b0,
        feedback_source_select: 1'b0,
        function_shutdown: 1'b0,
        power_shutdown: 1'b0,
        pecl_mode: 1'b0,
        sync_rising_active: 1'b1
    };

endpackage

//--- div_if.sv
// Carrier between the control logic and one modulus divider.
// Assumes the controller drives tick, clear and modulus on core_clk.
`timescale 1ns/1ns
interface div_if;
    import clk_synth_pkg::*;
    logic tick;
    logic clear;
    logic [DIV_W-1:0] modulus;
    logic pulse;
    modport ctrl (output tick, output clear, output modulus, input pulse);
    modport div (input tick, input clear, input modulus, output pulse);
endinterface

//--- pin_sync.sv
// Two-flop synchronisers for the asynchronous input pins.
// Assumes the pins change without regard to core_clk.
`timescale 1ns/1ns
module pin_sync #(
    parameter int N = 3
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [N-1:0] pins,
    output logic [N-1:0] pins_sync
);
    typedef struct packed {
        logic [N-1:0] meta;
        logic [N-1:0] stable;
    } sync_s;

    sync_s q;
    sync_s d;

    // The first stage feeds only the second stage.
    always_comb
    begin
        d.meta = pins;
        d.stable = q.meta;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= '0;
        else
            q <= d;
    end

    assign pins_sync = q.stable;
endmodule

//--- mod_divider.sv
// Integer modulus counter: one pulse for every modulus ticks.
// Assumes modulus is at least one whenever clear is low.
`timescale 1ns/1ns
module mod_divider (
    input wire logic core_clk,
    input wire logic rst_n,
    div_if.div bus
);
    import clk_synth_pkg::*;

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic pulse;
    } div_s;

    div_s q;
    div_s d;

    always_comb
    begin
        d = q;
        d.pulse = 1'b0;
        if (bus.clear)
        begin
            d.cnt = '0;
        end
        else if (bus.tick)
        begin
            if (q.cnt + DIV_W'(1) >= bus.modulus)
            begin
                d.cnt = '0;
                d.pulse = 1'b1;
            end
            else
            begin
                d.cnt = q.cnt + DIV_W'(1);
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= '0;
        else
            q <= d;
    end

    assign bus.pulse = q.pulse;
endmodule

//--- clk_synth_ctrl.sv
// Control logic of the clock synthesiser: source muxes, reference and
// feedback dividers, three-stage post divider, shutdown, output mode and
// phase restart from the synchronisation pin. Assumes core_clk runs at twice
// the VCO rate, so one core cycle is half a VCO period, and that the serial
// port hands each new configuration over with a one-cycle cfg_write.
`timescale 1ns/1ns
module clk_synth_ctrl (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic crystal_osc_clk,
    input wire logic ref_clk_pin,
    input wire logic sync_pin,
    input wire logic cfg_write,
    input wire logic [clk_synth_pkg::REF_W-1:0] cfg_ref_div_modulus,
    input wire logic [clk_synth_pkg::FB_W-1:0] cfg_feedback_divider_field,
    input wire logic [clk_synth_pkg::POST_W-1:0] cfg_post_div1_modulus,
    input wire logic [clk_synth_pkg::POST_W-1:0] cfg_post_div2_modulus,
    input wire logic [clk_synth_pkg::POST_W-1:0] cfg_post_div3_modulus,
    input wire logic cfg_ref_source_select,
    input wire logic cfg_feedback_source_select,
    input wire logic cfg_function_shutdown,
    input wire logic cfg_power_shutdown,
    input wire logic cfg_pecl_mode,
    input wire logic cfg_sync_rising_active,
    output logic [clk_synth_pkg::REF_W-1:0] ref_div_modulus,
    output logic [clk_synth_pkg::FB_W-1:0] fb_div_modulus,
    output logic [clk_synth_pkg::TOTAL_W-1:0] post_div_total_modulus,
    output logic ref_compare_pulse,
    output logic fb_compare_pulse,
    output logic clock_out_true,
    output logic clock_out_inverted,
    output logic out_cmos_enable,
    output logic out_pecl_enable,
    output logic osc_enable,
    output logic vco_enable,
    output logic bias_enable,
    output logic config_error,
    output logic sync_halted
);
    import clk_synth_pkg::*;

    typedef struct packed {
        cfg_s cfg;
        logic ref_prev;
        logic sync_prev;
        logic vco_phase;
        logic out_clk;
        sync_state_e sst;
        logic [DLY_W-1:0] dly;
        logic [TOTAL_W-1:0] total;
        logic clk_true;
        logic clk_inv;
        logic cmos_en;
        logic pecl_en;
        logic osc_en;
        logic vco_en;
        logic bias_en;
        logic cfg_err;
        logic halted;
    } ctrl_s;

    localparam ctrl_s CTRL_RESET = '{
        cfg: CFG_RESET,
        ref_prev: 1'b0,
        sync_prev: 1'b0,
        vco_phase: 1'b0,
        out_clk: 1'b0,
        sst: SYNC_RUN,
        dly: '0,
        total: '0,
        clk_true: 1'b0,
        clk_inv: 1'b0,
        cmos_en: 1'b0,
        pecl_en: 1'b0,
        osc_en: 1'b0,
        vco_en: 1'b0,
        bias_en: 1'b0,
        cfg_err: 1'b0,
        halted: 1'b0
    };

    ctrl_s q;
    ctrl_s d;

    logic [PIN_COUNT-1:0] pins_sync;
    logic ref_src;
    logic ref_tick;
    logic sync_now;
    logic sync_rise;
    logic sync_fall;
    logic active_edge;
    logic stop_edge;
    logic ref_bad;
    logic fb_bad;
    logic post_bad;
    logic fb_small_ok;
    logic loop_off;
    logic post_hold;
    logic out_rise;
    logic vco_tick;

    div_if ref_bus();
    div_if fb_bus();
    div_if post_bus[POST_STAGES]();

    pin_sync #(
        .N(PIN_COUNT)
    ) u_pin_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pins({sync_pin, ref_clk_pin, crystal_osc_clk}),
        .pins_sync(pins_sync)
    );

    mod_divider u_ref_div (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .bus(ref_bus)
    );

    mod_divider u_fb_div (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .bus(fb_bus)
    );

    // The first post stage counts core cycles and each later stage the pulses of the one before it, so the last
    // stage fires once per product of the three moduli.
    genvar gi;
    generate
        for (gi = 0; gi < POST_STAGES; gi++)
        begin : g_post
            mod_divider u_post_div (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .bus(post_bus[gi])
            );
            assign post_bus[gi].modulus =
                DIV_W'(q.cfg.post_mod[gi]);
            assign post_bus[gi].clear = post_hold;
            if (gi == 0)
            begin : g_first
                assign post_bus[gi].tick = 1'b1;
            end
            else
            begin : g_next
                assign post_bus[gi].tick = post_bus[gi-1].pulse;
            end
        end
    endgenerate

    // Source selection and edge detection on synchronised pins.
    always_comb
    begin
        ref_src = q.cfg.ref_source_select ? pins_sync[PIN_REF]
                                          : pins_sync[PIN_XTAL];
        ref_tick = ref_src & ~q.ref_prev;
        sync_now = pins_sync[PIN_SYNC];
        sync_rise = sync_now & ~q.sync_prev;
        sync_fall = ~sync_now & q.sync_prev;
        active_edge = q.cfg.sync_rising_active ? sync_rise
                                               : sync_fall;
        stop_edge = q.cfg.sync_rising_active ? sync_fall
                                             : sync_rise;
    end

    // Unsupported moduli hold their divider rather than run at a rate the
    // loop cannot reach.
    always_comb
    begin
        ref_bad = (q.cfg.ref_div_modulus == '0);
        fb_small_ok = (q.cfg.feedback_divider_field == FB_MOD_4) ||
                      (q.cfg.feedback_divider_field == FB_MOD_5) ||
                      (q.cfg.feedback_divider_field == FB_MOD_8) ||
                      (q.cfg.feedback_divider_field == FB_MOD_9) ||
                      (q.cfg.feedback_divider_field == FB_MOD_10);
        fb_bad = (q.cfg.feedback_divider_field < FB_MOD_FULL_MIN) &&
                 !fb_small_ok;
        post_bad = 1'b0;
        for (int i = 0; i < POST_STAGES; i++)
        begin
            post_bad = post_bad | (q.cfg.post_mod[i] == '0);
        end
        loop_off = q.cfg.function_shutdown |
                   q.cfg.power_shutdown;
        post_hold = loop_off | post_bad |
                    (q.sst == SYNC_STOP) | (q.sst == SYNC_ALIGN);
        vco_tick = q.vco_phase;
    end

    assign ref_bus.modulus = DIV_W'(q.cfg.ref_div_modulus);
    assign ref_bus.tick = ref_tick;
    assign ref_bus.clear = loop_off | ref_bad;
    assign fb_bus.modulus = q.cfg.feedback_divider_field;
    assign fb_bus.clear = loop_off | fb_bad;
    assign fb_bus.tick = q.cfg.feedback_source_select ? out_rise
                                                      : vco_tick;

    always_comb
    begin
        d = q;
        d.ref_prev = ref_src;
        d.sync_prev = sync_now;
        d.vco_phase = ~q.vco_phase;
        // Writes are taken in every power state so that software can
        // always wake the device again.
        if (cfg_write)
        begin
            d.cfg.ref_div_modulus = cfg_ref_div_modulus;
            d.cfg.feedback_divider_field = cfg_feedback_divider_field;
            d.cfg.post_mod[0] = cfg_post_div1_modulus;
            d.cfg.post_mod[1] = cfg_post_div2_modulus;
            d.cfg.post_mod[2] = cfg_post_div3_modulus;
            d.cfg.ref_source_select = cfg_ref_source_select;
            d.cfg.feedback_source_select = cfg_feedback_source_select;
            d.cfg.function_shutdown = cfg_function_shutdown;
            d.cfg.power_shutdown = cfg_power_shutdown;
            d.cfg.pecl_mode = cfg_pecl_mode;
            d.cfg.sync_rising_active = cfg_sync_rising_active;
        end
        // Toggling once per last-stage pulse gives equal high and low
        // halves of whole core cycles, so odd totals stay symmetric.
        if (post_bus[POST_STAGES-1].pulse)
        begin
            d.out_clk = ~q.out_clk;
        end
        case (q.sst)
            SYNC_RUN:
            begin
                if (stop_edge)
                begin
                    d.sst = SYNC_HALT;
                end
            end
            SYNC_HALT:
            begin
                // Never start a new high phase; stop once the clock is low
                // so the output shows no runt pulse.
                if (!q.out_clk || post_bus[POST_STAGES-1].pulse)
                begin
                    d.out_clk = 1'b0;
                    d.sst = SYNC_STOP;
                end
                if (active_edge)
                begin
                    d.out_clk = 1'b0;
                    d.sst = SYNC_ALIGN;
                    d.dly = SYNC_DELAY_LOAD;
                end
            end
            SYNC_STOP:
            begin
                d.out_clk = 1'b0;
                if (active_edge)
                begin
                    d.sst = SYNC_ALIGN;
                    d.dly = SYNC_DELAY_LOAD;
                end
            end
            SYNC_ALIGN:
            begin
                d.out_clk = 1'b0;
                if (stop_edge)
                begin
                    d.sst = SYNC_STOP;
                end
                else if (q.dly == '0)
                begin
                    // Restart on a whole core cycle, i.e. half a VCO period.
                    d.out_clk = 1'b1;
                    d.sst = SYNC_RUN;
                end
                else
                begin
                    d.dly = q.dly - DLY_W'(1);
                end
            end
            default:
            begin
                d.sst = SYNC_RUN;
            end
        endcase
        if (loop_off | post_bad)
        begin
            d.out_clk = 1'b0;
        end
        d.total = TOTAL_W'(q.cfg.post_mod[0]) *
                  TOTAL_W'(q.cfg.post_mod[1]) *
                  TOTAL_W'(q.cfg.post_mod[2]);
        d.clk_true = d.out_clk & ~q.cfg.function_shutdown;
        d.clk_inv = ~d.out_clk & ~q.cfg.function_shutdown;
        d.cmos_en = ~q.cfg.pecl_mode & ~q.cfg.function_shutdown;
        d.pecl_en = q.cfg.pecl_mode & ~q.cfg.function_shutdown;
        d.osc_en = ~q.cfg.power_shutdown;
        d.vco_en = ~q.cfg.power_shutdown;
        d.bias_en = ~q.cfg.power_shutdown;
        d.cfg_err = ref_bad | fb_bad | post_bad;
        d.halted = (d.sst == SYNC_STOP) | (d.sst == SYNC_ALIGN);
    end

    always_comb
    begin
        out_rise = post_bus[POST_STAGES-1].pulse & ~q.out_clk &
                   (q.sst == SYNC_RUN);
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= CTRL_RESET;
        else
            q <= d;
    end

    assign ref_div_modulus = q.cfg.ref_div_modulus;
    assign fb_div_modulus = q.cfg.feedback_divider_field;
    assign post_div_total_modulus = q.total;
    assign ref_compare_pulse = ref_bus.pulse;
    assign fb_compare_pulse = fb_bus.pulse;
    assign clock_out_true = q.clk_true;
    assign clock_out_inverted = q.clk_inv;
    assign out_cmos_enable = q.cmos_en;
    assign out_pecl_enable = q.pecl_en;
    assign osc_enable = q.osc_en;
    assign vco_enable = q.vco_en;
    assign bias_enable = q.bias_en;
    assign config_error = q.cfg_err;
    assign sync_halted = q.halted;
endmodule

//--- clk_sink.sv
// Downstream logic clocked by the synthesised output clock.
// Assumes core_clk is the finer time base for measuring phase lengths.
`timescale 1ns/1ns
module clk_sink (
    input wire logic core_clk,
    input wire logic clk_in,
    output int rise_count,
    output int high_len,
    output int low_len
);
    int run_len = 0;
    logic last = 1'b0;
    always @(posedge clk_in)
        rise_count <= rise_count + 1;
    // Phase lengths are counted in core cycles, each half a VCO period.
    always @(posedge core_clk)
    begin
        if (clk_in !== last)
        begin
            if (last === 1'b1)
                high_len <= run_len;
            else
                low_len <= run_len;
            run_len <= 1;
        end
        else
            run_len <= run_len + 1;
        last <= clk_in;
    end
endmodule

//--- clk_synth_properties.sv
// Concurrent checks on the clock synthesis control block.
// Sees only top module ports; bound from the bench top file.
`timescale 1ns/1ns
module clk_synth_properties (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cfg_write,
    input wire logic [clk_synth_pkg::REF_W-1:0] cfg_ref_div_modulus,
    input wire logic [clk_synth_pkg::FB_W-1:0] cfg_feedback_divider_field,
    input wire logic [clk_synth_pkg::POST_W-1:0] cfg_post_div1_modulus,
    input wire logic [clk_synth_pkg::POST_W-1:0] cfg_post_div2_modulus,
    input wire logic [clk_synth_pkg::POST_W-1:0] cfg_post_div3_modulus,
    input wire logic cfg_function_shutdown,
    input wire logic cfg_power_shutdown,
    input wire logic cfg_pecl_mode,
    input wire logic [clk_synth_pkg::REF_W-1:0] ref_div_modulus,
    input wire logic [clk_synth_pkg::FB_W-1:0] fb_div_modulus,
    input wire logic [clk_synth_pkg::TOTAL_W-1:0] post_div_total_modulus,
    input wire logic ref_compare_pulse,
    input wire logic clock_out_true,
    input wire logic out_cmos_enable,
    input wire logic out_pecl_enable,
    input wire logic osc_enable,
    input wire logic config_error,
    input wire logic sync_halted
);
    import clk_synth_pkg::*;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    logic [15:0] steady_q;
    logic [15:0] len_q;
    logic prev_q;
    logic run;
    logic cfg_bad;
    logic [TOTAL_W-1:0] cfg_total;
    assign cfg_total = TOTAL_W'(cfg_post_div1_modulus)
        * TOTAL_W'(cfg_post_div2_modulus) * TOTAL_W'(cfg_post_div3_modulus);
    assign cfg_bad = cfg_ref_div_modulus == 12'h000
        || cfg_total == 24'h000000
        || !(cfg_feedback_divider_field >= FB_MOD_FULL_MIN
        || cfg_feedback_divider_field inside {FB_MOD_4, FB_MOD_5, FB_MOD_8,
        FB_MOD_9, FB_MOD_10});
    assign run = !sync_halted && !config_error && osc_enable
        && (out_cmos_enable || out_pecl_enable);
    // Phases are judged only well after any start-up, so restarts never count.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            steady_q <= 16'h0000;
            len_q <= 16'h0000;
            prev_q <= 1'b0;
        end
        else
        begin
            prev_q <= clock_out_true;
            len_q <= (clock_out_true != prev_q) ? 16'h0001 : len_q + 16'h0001;
            if (!run || cfg_write)
                steady_q <= 16'h0000;
            else if (steady_q != 16'hFFFF)
                steady_q <= steady_q + 16'h0001;
        end
    end
    a_ref_mod_load: assert property (
        cfg_write |=> ref_div_modulus == $past(cfg_ref_div_modulus))
        else $error("reference modulus not loaded");
    a_fb_mod_load: assert property (
        cfg_write |=> fb_div_modulus == $past(cfg_feedback_divider_field))
        else $error("feedback modulus not loaded");
    a_total_product: assert property (
        cfg_write |-> ##2 post_div_total_modulus == $past(cfg_total, 2))
        else $error("post total is not the product");
    a_error_flag: assert property (
        cfg_write |-> ##2 config_error == $past(cfg_bad, 2))
        else $error("unsupported modulus flag wrong");
    a_stage_mode: assert property (
        cfg_write |-> ##2 out_pecl_enable == ($past(cfg_pecl_mode, 2)
        && !$past(cfg_function_shutdown, 2)) && out_cmos_enable
        == (!$past(cfg_pecl_mode, 2) && !$past(cfg_function_shutdown, 2)))
        else $error("output stage mode wrong");
    a_power_down: assert property (
        cfg_write |-> ##2 osc_enable == !$past(cfg_power_shutdown, 2))
        else $error("oscillator enable wrong");
    a_sync_stop_low: assert property (
        $rose(sync_halted) |-> !clock_out_true [*3])
        else $error("output not low while halted");
    a_duty_phase: assert property (
        (clock_out_true != prev_q) && {8'h00, steady_q}
        > 3 * post_div_total_modulus + 24'h000008
        |-> len_q == post_div_total_modulus)
        else $error("output phase length wrong");
    a_ref_pulse_gap: assert property (
        ref_compare_pulse |=> !ref_compare_pulse [*3])
        else $error("reference pulses too close");
    cover property (config_error);
    cover property ($rose(sync_halted));
    cover property (out_pecl_enable && clock_out_true);
endmodule

//--- pll_divider_clock_synth_bench.sv
// Self-checking bench for the clock synthesis control block.
// Drives every pin from the bench; a sink model watches the output clock.
`timescale 1ns/1ns
module pll_divider_clock_synth_bench;
    import clk_synth_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic crystal_osc_clk = 1'b0;
    logic ref_clk_pin = 1'b0;
    logic sync_pin = 1'b1;
    logic cfg_write = 1'b0;
    cfg_s cfg = CFG_RESET;
    logic [REF_W-1:0] ref_div_modulus;
    logic [FB_W-1:0] fb_div_modulus;
    logic [TOTAL_W-1:0] post_div_total_modulus;
    logic ref_compare_pulse, fb_compare_pulse, clock_out_true;
    logic clock_out_inverted, out_cmos_enable, out_pecl_enable;
    logic osc_enable, vco_enable, bias_enable, config_error, sync_halted;
    int miscompares = 0, check_count = 0, rises, high_len, low_len;
    int tick = 0, ref_pulses = 0, fb_pulses = 0, dr, df, dk, t, nr, lat0;
    int fb_q[$] = '{4, 5, 8, 9, 10, 11, 3, 0, 12, 13, 16383, 6, 7, 1};
    int ref_q[$] = '{1, 4095, 0, 2};
    int nf_q[$] = '{4, 9, 12, 5};
    clk_synth_ctrl dut (
        .core_clk, .rst_n, .crystal_osc_clk, .ref_clk_pin, .sync_pin,
        .cfg_write, .cfg_ref_div_modulus(cfg.ref_div_modulus),
        .cfg_feedback_divider_field(cfg.feedback_divider_field),
        .cfg_post_div1_modulus(cfg.post_mod[0]),
        .cfg_post_div2_modulus(cfg.post_mod[1]),
        .cfg_post_div3_modulus(cfg.post_mod[2]),
        .cfg_ref_source_select(cfg.ref_source_select),
        .cfg_feedback_source_select(cfg.feedback_source_select),
        .cfg_function_shutdown(cfg.function_shutdown),
        .cfg_power_shutdown(cfg.power_shutdown),
        .cfg_pecl_mode(cfg.pecl_mode),
        .cfg_sync_rising_active(cfg.sync_rising_active),
        .ref_div_modulus, .fb_div_modulus, .post_div_total_modulus,
        .ref_compare_pulse, .fb_compare_pulse, .clock_out_true,
        .clock_out_inverted, .out_cmos_enable, .out_pecl_enable,
        .osc_enable, .vco_enable, .bias_enable, .config_error, .sync_halted
    );
    clk_sink sink (.core_clk, .clk_in(clock_out_true), .rise_count(rises),
        .high_len, .low_len);
    always #20 core_clk = ~core_clk;
    // Crystal runs at a quarter of core_clk, the pin at a sixth, so a
    // wrong source choice shows in the pulse count.
    always @(negedge core_clk)
    begin
        tick <= tick + 1;
        if (tick % 2 == 0)
            crystal_osc_clk <= ~crystal_osc_clk;
        if (tick % 3 == 0)
            ref_clk_pin <= ~ref_clk_pin;
    end
    always @(posedge core_clk)
    begin
        if (ref_compare_pulse === 1'b1)
            ref_pulses <= ref_pulses + 1;
        if (fb_compare_pulse === 1'b1)
            fb_pulses <= fb_pulses + 1;
    end
    function automatic bit model_bad(int r, int f, int p);
        return r == 0 || p == 0 || !(f >= 12 || f inside {4, 5, 8, 9, 10});
    endfunction
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    // Free-running sources leave one pulse of phase uncertainty per window.
    task automatic near(string what, int exp, int got);
        check_count++;
        if (got > exp + 1 || got + 1 < exp)
        begin
            miscompares++;
            $display("wrong value %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic span(int n);
        int r0, f0, k0;
        r0 = ref_pulses;
        f0 = fb_pulses;
        k0 = rises;
        repeat (n) @(negedge core_clk);
        dr = ref_pulses - r0;
        df = fb_pulses - f0;
        dk = rises - k0;
    endtask
    task automatic apply();
        cfg_write = 1'b1;
        @(negedge core_clk);
        cfg_write = 1'b0;
        repeat (2) @(negedge core_clk);
        t = cfg.post_mod[0] * cfg.post_mod[1] * cfg.post_mod[2];
        chk("ref modulus", cfg.ref_div_modulus, ref_div_modulus);
        chk("fb modulus", cfg.feedback_divider_field,
            fb_div_modulus);
        chk("post total", t, post_div_total_modulus);
        chk("config error", model_bad(cfg.ref_div_modulus,
            cfg.feedback_divider_field, t), config_error);
        chk("pecl enable", cfg.pecl_mode & !cfg.function_shutdown,
            out_pecl_enable);
        chk("cmos enable", !cfg.pecl_mode & !cfg.function_shutdown,
            out_cmos_enable);
        chk("core enables", {3{!cfg.power_shutdown}},
            {osc_enable, vco_enable, bias_enable});
    endtask
    task automatic results();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        #800000;
        miscompares++;
        results();
    end
    initial
    begin
        void'($urandom(32'hB62ADC32));
        repeat (5) @(negedge core_clk);
        rst_n = 1'b1;
        foreach (fb_q[i])
        begin
            cfg.feedback_divider_field = FB_W'(fb_q[i]);
            cfg.ref_div_modulus = REF_W'(ref_q[i % 4]);
            cfg.post_mod[i % 3] = POST_W'(i % 5);
            apply();
        end
        cfg = CFG_RESET;
        repeat (6)
        begin
            for (int s = 0; s < 3; s++)
                cfg.post_mod[s] = POST_W'($urandom_range(3, 1));
            cfg.pecl_mode = 1'($urandom_range(1, 0));
            apply();
            span(8 * t + 20);
            chk("high phase", t, high_len);
            chk("low phase", t, low_len);
            span(16 * t);
            near("output edges", 8, dk);
            chk("inverted out", !clock_out_true,
                clock_out_inverted);
        end
        cfg.post_mod = {8'h01, 8'h02, 8'h01};
        for (int i = 0; i < 4; i++)
        begin
            nr = $urandom_range(5, 1);
            cfg.ref_source_select = i[0];
            cfg.feedback_source_select = i[1];
            cfg.ref_div_modulus = REF_W'(nr);
            cfg.feedback_divider_field = FB_W'(nf_q[i]);
            apply();
            span(1200);
            near("ref pulses", (i[0] ? 200 : 300) / nr, dr);
            near("fb pulses", (i[1] ? 300 : 600) / nf_q[i], df);
        end
        cfg.function_shutdown = 1'b1;
        cfg.power_shutdown = 1'b1;
        apply();
        span(600);
        chk("activity in shutdown", 0, dr + df + dk);
        cfg.ref_div_modulus = 12'h007;
        apply();
        cfg = CFG_RESET;
        cfg.post_mod = {8'h01, 8'h03, 8'h01};
        for (int i = 0; i < 4; i++)
        begin
            cfg.sync_rising_active = !i[1];
            sync_pin = !i[1];
            apply();
            repeat (20) @(negedge core_clk);
            chk("active edge in run", 0, sync_halted);
            sync_pin = i[1];
            repeat (12 + $urandom_range(7, 0)) @(negedge core_clk);
            chk("halted", 1, sync_halted);
            chk("halted output", 0, clock_out_true);
            sync_pin = !i[1];
            dk = 0;
            while (clock_out_true !== 1'b1 && dk < 40)
            begin
                @(negedge core_clk);
                dk++;
            end
            if (i == 0)
                lat0 = dk;
            chk("restart delay", lat0, dk);
        end
        // Two sync flops and the edge detector add three cycles of latency.
        chk("restart delay", SYNC_DELAY_CYCLES + 3, lat0);
        results();
    end
endmodule
bind clk_synth_ctrl clk_synth_properties chk (
    .core_clk, .rst_n, .cfg_write, .cfg_ref_div_modulus,
    .cfg_feedback_divider_field, .cfg_post_div1_modulus,
    .cfg_post_div2_modulus, .cfg_post_div3_modulus, .cfg_function_shutdown,
    .cfg_power_shutdown, .cfg_pecl_mode, .ref_div_modulus, .fb_div_modulus,
    .post_div_total_modulus, .ref_compare_pulse, .clock_out_true,
    .out_cmos_enable, .out_pecl_enable, .osc_enable, .config_error,
    .sync_halted
);
